//--- src/dps_device.sv
// synthesizer end: serial shift register, four frame latches, control word decode,
// per-channel lock detector and lock output selection
// assumes link lines are asynchronous to clk_i; divider pulses and taps come from clk_i logic
`timescale 1ns/10ps
`default_nettype none
// Function
// (RQ1) frames travel most significant bit first
// (RQ2) data bit shifted on each clock rise
// (RQ3) enable high copies shift register to latch
// (RQ4) last two bits pick destination latch
// (RQ5) host drives lines low when unpowered
// (RQ6) host loads reference before channel dividers
// (RQ7) host loads control before channel dividers
// (RQ8) control word fourteen bits, fixed field order
// (RQ9) polarity bit sets pump direction
// (RQ10) current pair selects 100 to 800 uA
// (RQ11) normal lock output from select pair
// (RQ12) sleeping channel reads locked; 00 low
// (RQ13) test taps of channel two side
// (RQ14) test taps of channel one side
// (RQ15) lock low on phase error, high locked
// (RQ16) locked after four close reference cycles
// (RQ17) channel sleep bit stops its divider
// (RQ18) reference sleep only when both sleep
// (RQ19) filter switch bit drives open-drain output
// (RQ20) reference frame carries twelve-bit value
// (RQ21) channel frame: swallow five, main twelve
// (RQ22) newest bits form frame, others kept
// (RQ23) host holds enable low while shifting
module dps_device (
    input  wire logic       clk_i,
    input  wire logic       rstn_i,
    dps_serial_if.dev       link,
    input  wire logic       ref_pulse_i,
    input  wire logic       ch1_pulse_i,
    input  wire logic       ch2_pulse_i,
    input  wire logic       ch1_modulus_tap_i,
    input  wire logic       ch2_modulus_tap_i,
    input  wire logic       ch1_compare_tap_i,
    input  wire logic       ch2_compare_tap_i,
    input  wire logic       ref_tap_i,
    input  wire logic       xtal_quarter_tap_i,
    input  wire logic       xtal_half_tap_i,
    output logic            test_mode_o,
    output logic            pump_polarity_o,
    output logic [1:0]      ch1_pump_current_o,
    output logic [1:0]      ch2_pump_current_o,
    output logic            ch1_run_o,
    output logic            ch2_run_o,
    output logic            ref_run_o,
    output logic [11:0]     ref_div_value_o,
    output logic [4:0]      ch1_swallow_o,
    output logic [11:0]     ch1_main_o,
    output logic [4:0]      ch2_swallow_o,
    output logic [11:0]     ch2_main_o,
    output logic            ch1_lock_o,
    output logic            ch2_lock_o,
    output logic            lock_indicator_out_o,
    output logic            loop_filter_tc_toggle_o,
    output logic            loop_filter_tc_toggle_oe_o
);
    import dps_pkg::*;

    // two-stage synchronisers; stage one feeds stage two only
    logic [2:0]           sync1_reg;
    logic [2:0]           sync2_reg;
    logic                 sck_last_reg;
    logic [FRAME_MAX-1:0] shift_reg;
    logic [CW_W-1:0]      synth_control_word_reg;
    logic [11:0]          ref_div_reg;
    logic [4:0]           ch1_swal_reg;
    logic [11:0]          ch1_main_reg;
    logic [4:0]           ch2_swal_reg;
    logic [11:0]          ch2_main_reg;
    logic [2:0]           run_reg;
    logic                 lock_out_reg;
    logic                 sw_oe_reg;
    wire logic [1:0]      locked;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sync1_reg    <= 3'h0;
            sync2_reg    <= 3'h0;
            sck_last_reg <= 1'b0;
        end else begin
            sync1_reg    <= {link.sen, link.sdata, link.sck};
            sync2_reg    <= sync1_reg;
            sck_last_reg <= sync2_reg[0];
        end
    end

    wire logic sck_rise = sync2_reg[0] & ~sck_last_reg;
    wire logic sdata_s  = sync2_reg[1];
    wire logic sen_s    = sync2_reg[2];
    wire dps_group_t grp = grp_of(shift_reg); // RQ4

    // newest bit enters at the bottom so the first bit ends up highest
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            shift_reg <= '0;
        end else if (sck_rise) begin
            shift_reg <= {shift_reg[FRAME_MAX-2:0], sdata_s}; // RQ1 RQ2
        end
    end

    // level sensitive: latch follows the shift register while enable stays high
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            synth_control_word_reg <= CTRL_RST;
            ref_div_reg            <= DIV_RST;
            ch1_swal_reg           <= SWAL_RST;
            ch1_main_reg           <= DIV_RST;
            ch2_swal_reg           <= SWAL_RST;
            ch2_main_reg           <= DIV_RST;
        end else if (sen_s) begin // RQ3
            unique case (grp) // RQ4 RQ22
                DPS_GRP_CTRL: synth_control_word_reg <= shift_reg[CW_W-1:0]; // RQ8
                DPS_GRP_CH1: begin
                    ch1_swal_reg <= shift_reg[SWAL_LSB +: SWAL_W]; // RQ21
                    ch1_main_reg <= shift_reg[MAIN_LSB +: DIV_W]; // RQ21
                end
                DPS_GRP_CH2: begin
                    ch2_swal_reg <= shift_reg[SWAL_LSB +: SWAL_W]; // RQ21
                    ch2_main_reg <= shift_reg[MAIN_LSB +: DIV_W]; // RQ21
                end
                DPS_GRP_REF: ref_div_reg <= shift_reg[DIV_LSB +: DIV_W]; // RQ20
            endcase
        end
    end

    wire logic sb1 = synth_control_word_reg[CW_SB1];
    wire logic sb2 = synth_control_word_reg[CW_SB2];
    wire logic ref_div_sleep = synth_control_word_reg[CW_SBR];
    // reference sleep is honoured only in full standby
    wire logic ref_on = ~(sb1 & sb2 & ref_div_sleep); // RQ18

    // lock detector: pulses of reference and channel must pair up inside the gap window
    logic [1:0] ch_pulse;
    assign ch_pulse = {ch2_pulse_i, ch1_pulse_i};

    for (genvar g = 0; g < 2; g++) begin : g_lock
        logic       pend_reg;
        logic       pend_ref_reg;
        logic [7:0] win_reg;
        logic [2:0] good_reg;
        logic       lock_reg;
        wire logic  hr   = ref_pulse_i;
        wire logic  hc   = ch_pulse[g];
        wire logic  both = hr & hc;
        wire logic  pair = pend_reg & ((pend_ref_reg & hc) | (~pend_ref_reg & hr));
        wire logic  late = pend_reg & (win_reg >= 8'(LOCK_GAP_CYC));
        wire logic  twice = pend_reg & ~pair & (hr | hc);
        wire logic  good = (both & ~pend_reg) | (pair & ~late);
        wire logic  bad  = late | twice;

        // one driver per lock bit: each channel owns its own flop
        assign locked[g] = lock_reg;

        always_ff @(posedge clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
                pend_reg     <= 1'b0;
                pend_ref_reg <= 1'b0;
                win_reg      <= 8'h00;
                good_reg     <= 3'h0;
                lock_reg     <= 1'b0;
            end else begin
                if (bad) begin
                    good_reg <= 3'h0;
                    lock_reg <= 1'b0; // RQ15
                end else if (good) begin
                    if (good_reg != LOCK_GOOD_CNT) begin
                        good_reg <= good_reg + 3'h1;
                    end
                    if (good_reg >= LOCK_GOOD_CNT - 3'h1) begin
                        lock_reg <= 1'b1; // RQ16
                    end
                end
                if (good | late) begin
                    pend_reg <= 1'b0;
                end else if ((hr | hc) & ~both) begin
                    pend_reg     <= 1'b1;
                    pend_ref_reg <= hr;
                    win_reg      <= 8'h01;
                end else if (pend_reg) begin
                    win_reg <= win_reg + 8'h01;
                end
            end
        end
    end

    logic lock_lvl;
    dps_lock_mux u_lock_mux (
        .test_i             (synth_control_word_reg[CW_TEST]),
        .sb1_i              (sb1),
        .sb2_i              (sb2),
        .sel_a_i            (synth_control_word_reg[CW_SEL_A]),
        .sel_b_i            (synth_control_word_reg[CW_SEL_B]),
        .lock1_i            (locked[0]),
        .lock2_i            (locked[1]),
        .ch1_modulus_tap_i  (ch1_modulus_tap_i),
        .ch2_modulus_tap_i  (ch2_modulus_tap_i),
        .ch1_compare_tap_i  (ch1_compare_tap_i),
        .ch2_compare_tap_i  (ch2_compare_tap_i),
        .ref_tap_i          (ref_tap_i),
        .xtal_quarter_tap_i (xtal_quarter_tap_i),
        .xtal_half_tap_i    (xtal_half_tap_i),
        .level_o            (lock_lvl)
    );

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            run_reg      <= 3'h0;
            lock_out_reg <= 1'b0;
            sw_oe_reg    <= 1'b0;
        end else begin
            run_reg      <= {ref_on, ~sb2, ~sb1}; // RQ17 RQ18
            lock_out_reg <= lock_lvl; // RQ11 RQ12 RQ13 RQ14
            // open drain: pull low while the switch bit is clear
            sw_oe_reg    <= ~synth_control_word_reg[CW_SW]; // RQ19
        end
    end

    assign test_mode_o                = synth_control_word_reg[CW_TEST];
    assign pump_polarity_o            = synth_control_word_reg[CW_POL]; // RQ9
    assign ch1_pump_current_o         = synth_control_word_reg[CW_CH1_CUR +: 2]; // RQ10
    assign ch2_pump_current_o         = synth_control_word_reg[CW_CH2_CUR +: 2]; // RQ10
    assign ch1_run_o                  = run_reg[0];
    assign ch2_run_o                  = run_reg[1];
    assign ref_run_o                  = run_reg[2];
    assign ref_div_value_o            = ref_div_reg;
    assign ch1_swallow_o              = ch1_swal_reg;
    assign ch1_main_o                 = ch1_main_reg;
    assign ch2_swallow_o              = ch2_swal_reg;
    assign ch2_main_o                 = ch2_main_reg;
    assign ch1_lock_o                 = locked[0];
    assign ch2_lock_o                 = locked[1];
    assign lock_indicator_out_o       = lock_out_reg;
    assign loop_filter_tc_toggle_o    = 1'b0;
    assign loop_filter_tc_toggle_oe_o = sw_oe_reg;
endmodule
`default_nettype wire

//--- src/dps_pkg.sv
// constants, types and helpers shared by both ends of the synthesizer serial control link
// assumes one 125 MHz system clock on each end
package dps_pkg;
    localparam int FRAME_MAX = 19;

    typedef enum logic [1:0] {
        DPS_GRP_CTRL = 2'h0,
        DPS_GRP_CH1  = 2'h1,
        DPS_GRP_CH2  = 2'h2,
        DPS_GRP_REF  = 2'h3
    } dps_group_t;

    localparam logic [4:0] CTRL_LEN = 5'h0E;
    localparam logic [4:0] REF_LEN  = 5'h0E;
    localparam logic [4:0] NDIV_LEN = 5'h13;

    // control word field positions, frame bit 0 is the last bit shifted
    localparam int CW_TEST    = 13;
    localparam int CW_POL     = 12;
    localparam int CW_CH1_CUR = 10;
    localparam int CW_SB1     = 9;
    localparam int CW_CH2_CUR = 7;
    localparam int CW_SB2     = 6;
    localparam int CW_SBR     = 5;
    localparam int CW_SEL_A   = 4;
    localparam int CW_SEL_B   = 3;
    localparam int CW_SW      = 2;
    localparam int CW_W       = 14;

    localparam int DIV_LSB  = 2;
    localparam int DIV_W    = 12;
    localparam int SWAL_LSB = 2;
    localparam int SWAL_W   = 5;
    localparam int MAIN_LSB = 7;

    localparam logic [13:0] CTRL_RST = 14'h0000;
    localparam logic [11:0] DIV_RST  = 12'h000;
    localparam logic [4:0]  SWAL_RST = 5'h00;

    // timing
    localparam int CLK_NS         = 8;
    localparam int OSC_PERIOD_NS  = 50;
    localparam int LOCK_GAP_NS    = 2 * OSC_PERIOD_NS;
    localparam int LOCK_GAP_RAW   = LOCK_GAP_NS / CLK_NS;
    localparam int LOCK_GAP_CYC   = (LOCK_GAP_RAW < 1) ? 1 : LOCK_GAP_RAW;
    localparam logic [2:0] LOCK_GOOD_CNT = 3'h4;
    localparam int SCK_HALF_NS    = 64;
    localparam int SCK_HALF_CYC   = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam int EN_HIGH_NS     = 64;
    localparam int EN_HIGH_CYC    = (EN_HIGH_NS + CLK_NS - 1) / CLK_NS;

    // host command registers
    localparam logic [3:0] HR_DATA   = 4'h0;
    localparam logic [3:0] HR_START  = 4'h4;
    localparam logic [3:0] HR_STATUS = 4'h8;
    localparam int ST_BUSY = 0;
    localparam int ST_REF  = 1;
    localparam int ST_CTRL = 2;
    localparam int ST_ERR  = 3;

    function automatic dps_group_t grp_of(input logic [FRAME_MAX-1:0] f);
        grp_of = dps_group_t'({f[0], f[1]});
    endfunction

    function automatic logic [4:0] frame_len(input dps_group_t g);
        frame_len = (g == DPS_GRP_CTRL) ? CTRL_LEN : (g == DPS_GRP_REF) ? REF_LEN : NDIV_LEN;
    endfunction
endpackage

//--- src/dps_serial_if.sv
// three-wire serial control link between host and synthesizer
// no clock: the device samples all three lines with its own clock
`timescale 1ns/10ps
`default_nettype none
interface dps_serial_if;
    logic sck;
    logic sdata;
    logic sen;

    modport host (output sck, output sdata, output sen);
    modport dev  (input sck, input sdata, input sen);
endinterface
`default_nettype wire

//--- src/dps_lock_mux.sv
// lock output source selection for normal and test modes
// assumes all inputs are on the device clock
`timescale 1ns/10ps
`default_nettype none
module dps_lock_mux (
    input  wire logic test_i,
    input  wire logic sb1_i,
    input  wire logic sb2_i,
    input  wire logic sel_a_i,
    input  wire logic sel_b_i,
    input  wire logic lock1_i,
    input  wire logic lock2_i,
    input  wire logic ch1_modulus_tap_i,
    input  wire logic ch2_modulus_tap_i,
    input  wire logic ch1_compare_tap_i,
    input  wire logic ch2_compare_tap_i,
    input  wire logic ref_tap_i,
    input  wire logic xtal_quarter_tap_i,
    input  wire logic xtal_half_tap_i,
    output logic      level_o
);
    wire logic [1:0] sel = {sel_a_i, sel_b_i};
    // a sleeping channel counts as locked
    wire logic eff1 = lock1_i | sb1_i; // RQ12
    wire logic eff2 = lock2_i | sb2_i; // RQ12
    wire logic norm_lvl = (sel == 2'h0) ? 1'b0 :
                          (sel == 2'h1) ? eff2 :
                          (sel == 2'h2) ? eff1 : (eff1 & eff2); // RQ11
    wire logic t_ch2 = (sel == 2'h0) ? 1'b0 :
                       (sel == 2'h1) ? ch2_modulus_tap_i :
                       (sel == 2'h2) ? ch2_compare_tap_i : ref_tap_i; // RQ13
    wire logic t_ch1 = (sel == 2'h0) ? xtal_quarter_tap_i :
                       (sel == 2'h1) ? ch1_modulus_tap_i :
                       (sel == 2'h2) ? ch1_compare_tap_i : xtal_half_tap_i; // RQ14
    wire logic test_lvl = (sb1_i & ~sb2_i) ? t_ch2 : (~sb1_i & sb2_i) ? t_ch1 : 1'b0; // RQ14

    assign level_o = test_i ? test_lvl : norm_lvl;
endmodule
`default_nettype wire

//--- src/dps_host.sv
// host end: sends one frame per command over the three-wire link
// assumes software on a plain strobe port, read data one cycle after the read strobe
`timescale 1ns/10ps
`default_nettype none
module dps_host (
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    dps_serial_if.host       link,
    input  wire logic [3:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    input  wire logic        dev_power_good_i,
    output logic [31:0]      rdata_o
);
    import dps_pkg::*;

    typedef enum logic [2:0] {HS_IDLE, HS_LOW, HS_HIGH, HS_EN, HS_GAP} dps_hstate_t;

    dps_hstate_t          state_reg;
    logic [FRAME_MAX-1:0] data_reg;
    logic [4:0]           idx_reg;
    logic [7:0]           tmr_reg;
    logic                 sck_reg;
    logic                 sdata_reg;
    logic                 sen_reg;
    logic                 ref_done_reg;
    logic                 ctrl_done_reg;
    logic                 err_reg;
    logic [31:0]          rdata_reg;
    logic [1:0]           pwr_sync_reg;

    wire logic       pwr_ok   = pwr_sync_reg[1];
    wire logic       busy     = (state_reg != HS_IDLE);
    wire dps_group_t grp      = grp_of(data_reg);
    wire logic       is_chan  = (grp == DPS_GRP_CH1) | (grp == DPS_GRP_CH2);
    wire logic       start_wr = wr_i & (addr_i == HR_START) & ~busy & pwr_ok;
    // channel frames before both reference and control frames are refused
    wire logic       refuse   = start_wr & is_chan & ~(ref_done_reg & ctrl_done_reg); // RQ6 RQ7
    wire logic       go       = start_wr & ~refuse;
    wire logic [4:0] top_idx  = frame_len(grp) - 5'h1;
    wire logic       tmr_done = (tmr_reg == 8'h01);
    wire logic       err_clr  = wr_i & (addr_i == HR_STATUS) & wdata_i[ST_ERR];
    wire logic [31:0] status  = {28'h0000000, err_reg, ctrl_done_reg, ref_done_reg, busy};
    wire logic [31:0] rd_mux  = (addr_i == HR_DATA)   ? {13'h0000, data_reg} :
                                (addr_i == HR_STATUS) ? status : 32'h00000000;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pwr_sync_reg <= 2'h0;
            rdata_reg    <= 32'h00000000;
            err_reg      <= 1'b0;
        end else begin
            pwr_sync_reg <= {pwr_sync_reg[0], dev_power_good_i};
            rdata_reg    <= rd_i ? rd_mux : 32'h00000000;
            // a refusal in the same cycle as the clear keeps the flag
            if (refuse) begin
                err_reg <= 1'b1;
            end else if (err_clr) begin
                err_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_reg     <= HS_IDLE;
            data_reg      <= '0;
            idx_reg       <= 5'h00;
            tmr_reg       <= 8'h00;
            sck_reg       <= 1'b0;
            sdata_reg     <= 1'b0;
            sen_reg       <= 1'b0;
            ref_done_reg  <= 1'b0;
            ctrl_done_reg <= 1'b0;
        end else if (!pwr_ok) begin
            // device unpowered: all lines low, order restarts at next power-up
            state_reg     <= HS_IDLE;
            sck_reg       <= 1'b0; // RQ5
            sdata_reg     <= 1'b0; // RQ5
            sen_reg       <= 1'b0; // RQ5
            ref_done_reg  <= 1'b0;
            ctrl_done_reg <= 1'b0;
        end else begin
            if (wr_i & (addr_i == HR_DATA) & ~busy) begin
                data_reg <= wdata_i[FRAME_MAX-1:0];
            end
            unique case (state_reg)
                HS_IDLE: begin
                    if (go) begin
                        idx_reg   <= top_idx;
                        sdata_reg <= data_reg[top_idx]; // RQ1
                        tmr_reg   <= 8'(SCK_HALF_CYC);
                        state_reg <= HS_LOW;
                    end
                end
                HS_LOW: begin
                    tmr_reg <= tmr_reg - 8'h01;
                    if (tmr_done) begin
                        sck_reg   <= 1'b1;
                        tmr_reg   <= 8'(SCK_HALF_CYC);
                        state_reg <= HS_HIGH;
                    end
                end
                HS_HIGH: begin
                    tmr_reg <= tmr_reg - 8'h01;
                    if (tmr_done) begin
                        sck_reg <= 1'b0;
                        tmr_reg <= 8'(SCK_HALF_CYC);
                        if (idx_reg == 5'h00) begin
                            state_reg <= HS_EN;
                        end else begin
                            idx_reg   <= idx_reg - 5'h01;
                            sdata_reg <= data_reg[idx_reg - 5'h01]; // RQ1
                            state_reg <= HS_LOW;
                        end
                    end
                end
                HS_EN: begin
                    // enable rises a half period after the last clock fall
                    tmr_reg <= tmr_reg - 8'h01;
                    if (tmr_done & ~sen_reg) begin
                        sen_reg <= 1'b1; // RQ23
                        tmr_reg <= 8'(EN_HIGH_CYC);
                    end else if (tmr_done) begin
                        sen_reg       <= 1'b0;
                        sdata_reg     <= 1'b0;
                        ref_done_reg  <= ref_done_reg | (grp == DPS_GRP_REF);
                        ctrl_done_reg <= ctrl_done_reg | (grp == DPS_GRP_CTRL);
                        tmr_reg       <= 8'(SCK_HALF_CYC);
                        state_reg     <= HS_GAP;
                    end
                end
                HS_GAP: begin
                    tmr_reg <= tmr_reg - 8'h01;
                    if (tmr_done) begin
                        state_reg <= HS_IDLE;
                    end
                end
            endcase
        end
    end

    assign link.sck   = sck_reg;
    assign link.sdata = sdata_reg;
    assign link.sen   = sen_reg;
    assign rdata_o    = rdata_reg;
endmodule
`default_nettype wire

//--- sim/dps_link_properties.sv
// concurrent checks on the three-wire link between host and device
// assumes the host drives every link line from registers on clk_i
`timescale 1ns/10ps
`default_nettype none
module dps_link_properties (
    input  wire logic clk_i,
    input  wire logic rstn_i,
    input  wire logic sck,
    input  wire logic sdata,
    input  wire logic sen
);
    import dps_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    logic [4:0] rises_reg;
    // bits clocked since the last latch pulse
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i)
            rises_reg <= 5'h00;
        else if ($fell(sen))
            rises_reg <= 5'h00;
        else if ($rose(sck))
            rises_reg <= rises_reg + 5'h01;
    end
    sequence sck_high_phase;
        sck [*8] ##1 !sck;
    endsequence
    sequence latch_pulse;
        sen [*8] ##1 !sen;
    endsequence
    chk_data_steady: assert property (sck && $past(sck) |-> $stable(sdata))
        else $error("data moved while clock high");
    chk_sck_high_len: assert property ($rose(sck) |-> sck_high_phase)
        else $error("clock high phase wrong");
    chk_sck_low_len: assert property ($fell(sck) |-> !sck [*8])
        else $error("clock low phase short");
    chk_sen_not_shift: assert property (sen |-> !sck)
        else $error("clock high during latch");
    chk_sen_pulse_len: assert property ($rose(sen) |-> latch_pulse)
        else $error("latch pulse length wrong");
    chk_sen_after_bits: assert property ($rose(sen) |-> !$past(sck, 8))
        else $error("latch too soon after last bit");
    chk_frame_length: assert property ($rose(sen) |-> rises_reg == CTRL_LEN || rises_reg == NDIV_LEN)
        else $error("frame bit count wrong");
    chk_gap_after_latch: assert property ($fell(sen) |-> !sck [*8])
        else $error("clock too soon after latch");
endmodule
`default_nettype wire

//--- sim/testbench.sv
// self-checking bench: host and device joined by the link, driven over the host port
// assumes the host register map and control field positions of the design package
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import dps_pkg::*;
    localparam logic [13:0] CW [5] = '{14'h18BC, 14'h0C58, 14'h373C, 14'h2278, 14'h2050};
    localparam logic        LK [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
    logic        clk_i = 1'b0, rstn_i = 1'b0, wr = 1'b0, rd = 1'b0, pg = 1'b1;
    logic [3:0]  addr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata, st;
    logic [5:0]  pcnt = 6'h00;
    logic [6:0]  taps = 7'h14;
    logic [18:0] wire_bits = 19'h0;
    logic        pol, ref_run, c1run, c2run, lock, oe, tm, lk1, lk2, swd;
    logic [1:0]  cur1, cur2;
    logic [11:0] rdiv, m1, m2;
    logic [4:0]  s1, s2;
    int          failures = 0, samples_checked = 0;
    dps_serial_if i_dps_serial_if ();
    dps_host i_dps_host (.clk_i, .rstn_i, .link(i_dps_serial_if.host), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .dev_power_good_i(pg), .rdata_o(rdata));
    // channel 1 pulses coincide with the reference, channel 2 lags by 20 cycles
    dps_device i_dps_device (.clk_i, .rstn_i, .link(i_dps_serial_if.dev), .ref_pulse_i(pcnt == 6'h00),
        .ch1_pulse_i(pcnt == 6'h00), .ch2_pulse_i(pcnt == 6'h14), .ch1_modulus_tap_i(taps[0]),
        .ch2_modulus_tap_i(taps[1]), .ch1_compare_tap_i(taps[2]), .ch2_compare_tap_i(taps[3]),
        .ref_tap_i(taps[4]), .xtal_quarter_tap_i(taps[5]), .xtal_half_tap_i(taps[6]), .test_mode_o(tm),
        .pump_polarity_o(pol), .ch1_pump_current_o(cur1), .ch2_pump_current_o(cur2), .ch1_run_o(c1run),
        .ch2_run_o(c2run), .ref_run_o(ref_run), .ref_div_value_o(rdiv), .ch1_swallow_o(s1), .ch1_main_o(m1),
        .ch2_swallow_o(s2), .ch2_main_o(m2), .ch1_lock_o(lk1), .ch2_lock_o(lk2), .lock_indicator_out_o(lock),
        .loop_filter_tc_toggle_o(swd), .loop_filter_tc_toggle_oe_o(oe));
    dps_link_properties i_dps_link_properties (.clk_i, .rstn_i, .sck(i_dps_serial_if.sck),
        .sdata(i_dps_serial_if.sdata), .sen(i_dps_serial_if.sen));
    initial begin
        forever #4 clk_i = ~clk_i;
    end
    always @(posedge clk_i) pcnt <= (pcnt == 6'h27) ? 6'h00 : pcnt + 6'h01;
    always @(posedge i_dps_serial_if.sck) wire_bits <= {wire_bits[17:0], i_dps_serial_if.sdata};
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_i);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_i);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic send(input logic [18:0] f, input int len);
        wr_reg(HR_DATA, {13'h0, f});
        wr_reg(HR_START, 32'h0);
        st = 32'h1;
        for (int i = 0; i < 400 && st[ST_BUSY]; i++) rd_reg(HR_STATUS, st);
        check("busy", st[ST_BUSY], 1'b0);
        check("wire", wire_bits & ((19'h1 << len) - 19'h1), f);
    endtask
    // channel 1 frame; status is read before the error flag is cleared
    task automatic try_ch1;
        wr_reg(HR_DATA, 32'h00023642);
        wr_reg(HR_START, 32'h0);
        rd_reg(HR_STATUS, st);
        wr_reg(HR_STATUS, 32'h8);
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_i);
        failures++;
        close_out();
    end
    initial begin
        repeat (20) @(posedge clk_i);
        rstn_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        try_ch1();
        check("refused", {st[ST_ERR], st[ST_BUSY]}, 2'b10);
        send(19'h00D4B, 14);
        check("ref", rdiv, 12'h352);
        try_ch1();
        check("refused", {st[ST_ERR], st[ST_BUSY]}, 2'b10);
        for (int i = 0; i < 5; i++) begin
            send({5'h00, CW[i]}, 14);
            check("test", tm, CW[i][CW_TEST]);
            check("pol", pol, CW[i][CW_POL]);
            check("cur", {cur1, cur2}, {CW[i][CW_CH1_CUR +: 2], CW[i][CW_CH2_CUR +: 2]});
            check("run", {c1run, c2run, ref_run}, {~CW[i][CW_SB1], ~CW[i][CW_SB2],
                ~(CW[i][CW_SB1] & CW[i][CW_SB2] & CW[i][CW_SBR])});
            check("lock", lock, LK[i]);
            check("sw", {swd, oe}, {1'b0, ~CW[i][CW_SW]});
            if (i == 0)
                check("locks", {lk1, lk2}, 2'b10);
        end
        send(19'h23642, 19);
        check("ch1", {m1, s1, m2, s2}, {12'h46C, 5'h10, 12'h000, 5'h00});
        send(19'h242A1, 19);
        check("ch2", {m1, s1, m2, s2, rdiv}, {12'h46C, 5'h10, 12'h485, 5'h08, 12'h352});
        pg <= 1'b0;
        repeat (4) @(posedge clk_i);
        check("lines", {i_dps_serial_if.sck, i_dps_serial_if.sdata, i_dps_serial_if.sen}, 3'h0);
        pg <= 1'b1;
        repeat (4) @(posedge clk_i);
        // control frame alone: the missing reference frame must still refuse
        send({5'h00, CW[1]}, 14);
        try_ch1();
        check("refused", {st[ST_ERR], st[ST_BUSY]}, 2'b10);
        close_out();
    end
endmodule
`default_nettype wire
